/* File: rtl/aic_analog_input.sv */
// analogue input conditioning: range, scaling, filter and gating
// assumes a classic wishbone master and a sample in 0.01 ma / 0.01 v
//
// Operation
// - function codes: off and process value
// - comparator value delivered even when off
// - code 0: current with 4 ma live zero
// - code 1: current full scale from zero
// - code 4: voltage zero to ten volts
// - code 5: voltage with 2 v live zero
// - codes 2 and 6 use span settings
// - jumper limits accepted range codes
// - jumper change never rewrites range code
// - span low clamps to scale, defaults 4 ma
// - span high clamps to scale, defaults 20 ma
// - span settings writable only in user range
// - low endpoint selects min, max or user
// - high endpoint selects min, max or user
// - user endpoints clamp to plus/minus ten thousand
// - first-order filter, 1 ms to 10 s
// - enable: always, gate low, gate high
// - unit follows range: volts or milliamps
// - digital function 11 drives the gate
// - inputs sharing function 11 are ored
//
// Added by the designer: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
module aic_analog_input #(
  parameter int TICK_CYC = aic_pkg::TICK_CYCLES // cycles per ms
) (
  input  wire logic                       clk,     // 125 mhz clock
  input  wire logic                       rst,     // sync reset, high
  input  wire aic_pkg::aic_wb_req_t       wb_req,  // wishbone request
  output logic [31:0]                     wb_dat_o, // read data
  output logic                            wb_ack_o, // cycle done
  input  wire logic                       adc_valid, // sample strobe
  input  wire logic [10:0]                adc_sample, // 0.01 units
  input  wire logic                       current_voltage_jumper, // 1=v
  input  wire logic [aic_pkg::N_DIN-1:0]  dig_in,  // digital inputs
  output logic signed [31:0]              process_value, // scaled
  output logic                            process_valid, // in use
  output logic signed [31:0]              comparator_value, // always
  output logic                            input_active, // enabled
  output logic                            unit_is_volt  // 1 = volts
);
  import aic_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    aic_cfg_t           cfg;
    logic               ack;
    logic [31:0]        dat;
    logic [16:0]        tick_cnt;
    logic               tick;
    logic [10:0]        sample;
    logic signed [31:0] proc;
    logic signed [31:0] cond;
    logic               active;
  } aic_state_t;

  aic_state_t st_ff;
  aic_state_t nxt_st;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic is_volt(input logic [2:0] code);
    return code == RANGE_0_10V || code == RANGE_2_10V ||
           code == RANGE_USER_V;
  endfunction

  function automatic logic is_user(input logic [2:0] code);
    return code == RANGE_USER_I || code == RANGE_USER_V;
  endfunction

  function automatic logic range_legal(input logic [2:0] code);
    return code != 3'h3 && code != 3'h7;
  endfunction

  // byte lanes merge into the old word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [10:0] clamp_phys(input logic [31:0] v,
                                             input logic volt);
    logic [10:0] top;
    top = volt ? PHYS_10V : PHYS_20MA;
    return (v > {21'h0, top}) ? top : v[10:0];
  endfunction

  function automatic logic signed [31:0] clamp_user(
      input logic signed [31:0] v);
    if (v > USER_LIM) begin
      return USER_LIM;
    end else if (v < -USER_LIM) begin
      return -USER_LIM;
    end
    return v;
  endfunction

  function automatic logic signed [31:0] endpoint(
      input logic [1:0] sel, input aic_cfg_t c,
      input logic signed [31:0] usr);
    unique case (sel)
      SCL_MAX:  return c.proc_max;
      SCL_USER: return usr;
      default:  return c.proc_min;
    endcase
  endfunction

  // ****************************************************************
  // gate from digital inputs
  // ****************************************************************
  logic gate;
  logic act;

  // every input carrying the gate function contributes
  always_comb begin
    gate = 1'b0;
    for (int i = 0; i < N_DIN; i++) begin
      if (st_ff.cfg.din_func[i*5 +: 5] == DIN_GATE_FUNC) begin
        gate = gate | dig_in[i];
      end
    end
  end

  // enable selector; codes above 2 never get stored
  always_comb begin
    unique case (st_ff.cfg.en_sel)
      EN_LOW:  act = ~gate;
      EN_HIGH: act = gate;
      default: act = 1'b1;
    endcase
  end

  // ****************************************************************
  // physical span and scaling
  // ****************************************************************
  logic [10:0]        x_lo;
  logic [10:0]        x_hi;
  logic [10:0]        x_c;
  logic signed [31:0] y_lo;
  logic signed [31:0] y_hi;
  logic signed [47:0] prod;
  logic signed [47:0] quot;
  logic signed [31:0] mapped;
  logic signed [31:0] filt_y;

  // fixed ranges ignore the span registers
  always_comb begin
    unique case (st_ff.cfg.range)
      RANGE_4_20MA: begin
        x_lo = PHYS_4MA;
        x_hi = PHYS_20MA;
      end
      RANGE_0_20MA: begin
        x_lo = 11'h000;
        x_hi = PHYS_20MA;
      end
      RANGE_0_10V: begin
        x_lo = 11'h000;
        x_hi = PHYS_10V;
      end
      RANGE_2_10V: begin
        x_lo = PHYS_2V;
        x_hi = PHYS_10V;
      end
      default: begin
        x_lo = st_ff.cfg.span_lo;
        x_hi = st_ff.cfg.span_hi;
      end
    endcase
  end

  // linear map; an empty or inverted span yields the low endpoint
  always_comb begin
    y_lo = endpoint(st_ff.cfg.lo_sel, st_ff.cfg,
                    st_ff.cfg.lo_user);
    y_hi = endpoint(st_ff.cfg.hi_sel, st_ff.cfg,
                    st_ff.cfg.hi_user);
    if (st_ff.sample < x_lo) begin
      x_c = x_lo;
    end else if (st_ff.sample > x_hi) begin
      x_c = x_hi;
    end else begin
      x_c = st_ff.sample;
    end
    prod = $signed({37'h0, x_c - x_lo}) *
           ($signed({{16{y_hi[31]}}, y_hi}) -
            $signed({{16{y_lo[31]}}, y_lo}));
    quot = '0;
    if (x_hi > x_lo) begin
      quot = prod / $signed({37'h0, x_hi - x_lo});
    end
    mapped = y_lo + quot[31:0];
  end

  aic_lp_filter u_filt (
    .clk   (clk),
    .rst   (rst),
    .tick  (st_ff.tick),
    .en    (act),
    .tc_ms (st_ff.cfg.filt),
    .x     (mapped),
    .y     (filt_y)
  );

  // ****************************************************************
  // next state: bus slave, config writes, tick, outputs
  // ****************************************************************
  logic        req;
  logic        wr;
  logic [31:0] wd;
  logic [31:0] rd;
  logic        volt_j;

  always_comb begin
    nxt_st = st_ff;
    req    = wb_req.cyc & wb_req.stb;
    // write lands on the edge that sees ack high
    wr     = req & wb_req.we & st_ff.ack;
    volt_j = current_voltage_jumper;
    wd     = '0;
    rd     = '0;

    // one-cycle ack; dropped the cycle after it was given
    nxt_st.ack = req & ~st_ff.ack;

    // read mux, unmapped reads as zero
    unique case (wb_req.adr)
      REG_CTRL: begin
        rd[CTRL_FUNC_LSB  +: 2] = st_ff.cfg.func;
        rd[CTRL_RANGE_LSB +: 3] = st_ff.cfg.range;
        rd[CTRL_EN_LSB    +: 2] = st_ff.cfg.en_sel;
        rd[CTRL_LOSEL_LSB +: 2] = st_ff.cfg.lo_sel;
        rd[CTRL_HISEL_LSB +: 2] = st_ff.cfg.hi_sel;
      end
      REG_SPAN_LOW:  rd = {21'h0, st_ff.cfg.span_lo};
      REG_SPAN_HIGH: rd = {21'h0, st_ff.cfg.span_hi};
      REG_LOW_USER:  rd = st_ff.cfg.lo_user;
      REG_HIGH_USER: rd = st_ff.cfg.hi_user;
      REG_FILTER:    rd = {18'h0, st_ff.cfg.filt};
      REG_DIN_FUNC:  rd = {12'h0, st_ff.cfg.din_func};
      REG_PROC_MIN:  rd = st_ff.cfg.proc_min;
      REG_PROC_MAX:  rd = st_ff.cfg.proc_max;
      REG_STATUS:    rd = {27'h0, volt_j,
                           is_volt(st_ff.cfg.range), gate,
                           st_ff.active,
                           st_ff.cfg.func == FUNC_PROCESS};
      REG_PROC_VAL:  rd = st_ff.proc;
      REG_COND_VAL:  rd = st_ff.cond;
      default:       rd = '0;
    endcase
    if (req & ~st_ff.ack) begin
      nxt_st.dat = rd;
    end

    // config writes; illegal control fields keep the old setting, filter, span and user values clamp
    if (wr) begin
      wd = merge(rd, wb_req.dat, wb_req.sel);
      unique case (wb_req.adr)
        REG_CTRL: begin
          if (wd[CTRL_FUNC_LSB +: 2] == FUNC_OFF ||
              wd[CTRL_FUNC_LSB +: 2] == FUNC_PROCESS) begin
            nxt_st.cfg.func = wd[CTRL_FUNC_LSB +: 2];
          end
          // range code must match the jumper class
          if (range_legal(wd[CTRL_RANGE_LSB +: 3]) &&
              is_volt(wd[CTRL_RANGE_LSB +: 3]) == volt_j) begin
            nxt_st.cfg.range = wd[CTRL_RANGE_LSB +: 3];
          end
          if (wd[CTRL_EN_LSB +: 2] != 2'h3) begin
            nxt_st.cfg.en_sel = wd[CTRL_EN_LSB +: 2];
          end
          if (wd[CTRL_LOSEL_LSB +: 2] != 2'h3) begin
            nxt_st.cfg.lo_sel = wd[CTRL_LOSEL_LSB +: 2];
          end
          if (wd[CTRL_HISEL_LSB +: 2] != 2'h3) begin
            nxt_st.cfg.hi_sel = wd[CTRL_HISEL_LSB +: 2];
          end
        end
        REG_SPAN_LOW: begin
          if (is_user(st_ff.cfg.range)) begin
            nxt_st.cfg.span_lo =
              clamp_phys(wd, is_volt(st_ff.cfg.range));
          end
        end
        REG_SPAN_HIGH: begin
          if (is_user(st_ff.cfg.range)) begin
            nxt_st.cfg.span_hi =
              clamp_phys(wd, is_volt(st_ff.cfg.range));
          end
        end
        REG_LOW_USER:  nxt_st.cfg.lo_user = clamp_user(wd);
        REG_HIGH_USER: nxt_st.cfg.hi_user = clamp_user(wd);
        REG_FILTER: begin
          if (wd > {18'h0, FILT_MAX}) begin
            nxt_st.cfg.filt = FILT_MAX;
          end else if (wd < {18'h0, FILT_MIN}) begin
            nxt_st.cfg.filt = FILT_MIN;
          end else begin
            nxt_st.cfg.filt = wd[13:0];
          end
        end
        REG_DIN_FUNC:  nxt_st.cfg.din_func = wd[19:0];
        REG_PROC_MIN:  nxt_st.cfg.proc_min = wd;
        REG_PROC_MAX:  nxt_st.cfg.proc_max = wd;
        default: begin
        end
      endcase
    end

    // millisecond tick for the filter
    nxt_st.tick = 1'b0;
    if (st_ff.tick_cnt == 17'(TICK_CYC - 1)) begin
      nxt_st.tick_cnt = '0;
      nxt_st.tick     = 1'b1;
    end else begin
      nxt_st.tick_cnt = st_ff.tick_cnt + 17'h00001;
    end

    // latest converter sample
    if (adc_valid) begin
      nxt_st.sample = adc_sample;
    end

    // comparators see the value whatever the function code
    nxt_st.active = act;
    nxt_st.cond   = filt_y;
    nxt_st.proc   = (act && st_ff.cfg.func == FUNC_PROCESS) ?
                    filt_y : 32'sh0;
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  // jumper never touches the stored range code
  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff     <= '0;
      st_ff.cfg <= CFG_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign wb_dat_o         = st_ff.dat;
  assign wb_ack_o         = st_ff.ack;
  assign process_value    = st_ff.proc;
  assign process_valid    = st_ff.active &
                            (st_ff.cfg.func == FUNC_PROCESS);
  assign comparator_value = st_ff.cond;
  assign input_active     = st_ff.active;
  assign unit_is_volt     = is_volt(st_ff.cfg.range);
endmodule

/* File: rtl/aic_lp_filter.sv */
// first-order low-pass stepped by a millisecond tick
// assumes tc_ms is never zero; the caller clamps it
`timescale 1ns/1ps
module aic_lp_filter (
  input  wire logic               clk,   // system clock
  input  wire logic               rst,   // sync reset, high
  input  wire logic               tick,  // one step per pulse
  input  wire logic               en,    // step only when set
  input  wire logic [13:0]        tc_ms, // time constant in ms
  input  wire logic signed [31:0] x,     // unfiltered value
  output logic signed [31:0]      y      // filtered value
);
  import aic_pkg::*;

  typedef struct packed {
    logic signed [47:0] acc;
  } aic_filt_t;

  aic_filt_t st_ff;
  aic_filt_t nxt_st;
  logic signed [47:0] err;

  // y += (x - y) * ts / tc; 16 fraction bits keep slow filters moving
  always_comb begin
    nxt_st = st_ff;
    err    = $signed({x, 16'h0000}) - st_ff.acc;
    if (tick && en) begin
      nxt_st.acc = st_ff.acc + err / $signed({34'h0, tc_ms});
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign y = st_ff.acc[47:16];
endmodule

/* File: rtl/aic_pkg.sv */
// constants, field layouts and carrier types of the analogue input block
// assumes a 125 mhz clock and physical values in steps of 0.01 ma / 0.01 v
package aic_pkg;
  // ****************************************************************
  // register map (byte addresses, one word each)
  // ****************************************************************
  localparam logic [5:0] REG_CTRL      = 6'h00;
  localparam logic [5:0] REG_SPAN_LOW  = 6'h04;
  localparam logic [5:0] REG_SPAN_HIGH = 6'h08;
  localparam logic [5:0] REG_LOW_USER  = 6'h0c;
  localparam logic [5:0] REG_HIGH_USER = 6'h10;
  localparam logic [5:0] REG_FILTER    = 6'h14;
  localparam logic [5:0] REG_DIN_FUNC  = 6'h18;
  localparam logic [5:0] REG_PROC_MIN  = 6'h1c;
  localparam logic [5:0] REG_PROC_MAX  = 6'h20;
  localparam logic [5:0] REG_STATUS    = 6'h24;
  localparam logic [5:0] REG_PROC_VAL  = 6'h28;
  localparam logic [5:0] REG_COND_VAL  = 6'h2c;
  // ****************************************************************
  // control word field positions
  // ****************************************************************
  localparam int CTRL_FUNC_LSB  = 0;
  localparam int CTRL_RANGE_LSB = 4;
  localparam int CTRL_EN_LSB    = 8;
  localparam int CTRL_LOSEL_LSB = 12;
  localparam int CTRL_HISEL_LSB = 16;
  // ****************************************************************
  // mode codes
  // ****************************************************************
  localparam logic [1:0] FUNC_OFF     = 2'h0;
  localparam logic [1:0] FUNC_PROCESS = 2'h3;
  localparam logic [2:0] RANGE_4_20MA = 3'h0;
  localparam logic [2:0] RANGE_0_20MA = 3'h1;
  localparam logic [2:0] RANGE_USER_I = 3'h2;
  localparam logic [2:0] RANGE_0_10V  = 3'h4;
  localparam logic [2:0] RANGE_2_10V  = 3'h5;
  localparam logic [2:0] RANGE_USER_V = 3'h6;
  localparam logic [1:0] EN_ALWAYS    = 2'h0;
  localparam logic [1:0] EN_LOW       = 2'h1;
  localparam logic [1:0] EN_HIGH      = 2'h2;
  localparam logic [1:0] SCL_MIN      = 2'h0;
  localparam logic [1:0] SCL_MAX      = 2'h1;
  localparam logic [1:0] SCL_USER     = 2'h2;
  localparam logic [4:0] DIN_GATE_FUNC = 5'h0b;
  // ****************************************************************
  // physical levels in hundredths, user limits in thousandths
  // ****************************************************************
  localparam logic [10:0] PHYS_4MA  = 11'h190;
  localparam logic [10:0] PHYS_20MA = 11'h7d0;
  localparam logic [10:0] PHYS_2V   = 11'h0c8;
  localparam logic [10:0] PHYS_10V  = 11'h3e8;
  localparam logic signed [31:0] USER_LIM = 32'sh00989680;
  localparam logic [13:0] FILT_DEF  = 14'h0064;
  localparam logic [13:0] FILT_MIN  = 14'h0001;
  localparam logic [13:0] FILT_MAX  = 14'h2710;
  // ****************************************************************
  // timing: the filter steps once per millisecond
  // ****************************************************************
  localparam int CLK_NS  = 8;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYCLES = TICK_NS / CLK_NS;
  localparam int N_DIN = 4;
  // ****************************************************************
  // carrier types
  // ****************************************************************
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [5:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } aic_wb_req_t;

  typedef struct packed {
    logic [1:0]        func;
    logic [2:0]        range;
    logic [1:0]        en_sel;
    logic [1:0]        lo_sel;
    logic [1:0]        hi_sel;
    logic [10:0]       span_lo;
    logic [10:0]       span_hi;
    logic signed [31:0] lo_user;
    logic signed [31:0] hi_user;
    logic [13:0]       filt;
    logic [19:0]       din_func;
    logic signed [31:0] proc_min;
    logic signed [31:0] proc_max;
  } aic_cfg_t;

  localparam aic_cfg_t CFG_RST = '{
    func: FUNC_PROCESS, range: RANGE_4_20MA, en_sel: EN_ALWAYS,
    lo_sel: SCL_MIN, hi_sel: SCL_MAX, span_lo: PHYS_4MA,
    span_hi: PHYS_20MA, lo_user: 32'sh0, hi_user: 32'sh0,
    filt: FILT_DEF, din_func: 20'h0, proc_min: 32'sh0,
    proc_max: 32'sh0};
endpackage

/* File: sim/aic_adc_src.sv */
// sample source standing in for the converter behind the analogue pin
// assumes the bench sets level; strobes one sample every fourth cycle
`timescale 1ns/1ps
module aic_adc_src (
  input  wire logic        clk,        // system clock
  input  wire logic        rst,        // sync reset, high
  input  wire logic [10:0] level,      // value to convert
  output logic             adc_valid,  // sample strobe
  output logic [10:0]      adc_sample  // converted value
);
  logic [1:0] cnt_ff;
  // outside the strobe the bus shows junk, so a held value is never trusted
  always_ff @(posedge clk) begin
    cnt_ff     <= rst ? 2'h0 : cnt_ff + 2'h1;
    adc_valid  <= !rst && cnt_ff == 2'h2;
    adc_sample <= (!rst && cnt_ff == 2'h2) ? level : ~level;
  end
endmodule

/* File: sim/aic_analog_input_chk.sv */
// checker: bus handshake, gating and filter pacing at the block's ports
// assumes binding to aic_analog_input with TICK_CYC of at least 7
`timescale 1ns/1ps
module aic_analog_input_chk #(
  parameter int TICK_CYC = 8 // cycles per ms
) (
  input wire logic                clk,                    // clock
  input wire logic                rst,                    // reset
  input wire aic_pkg::aic_wb_req_t wb_req,                // request
  input wire logic [31:0]         wb_dat_o,               // read data
  input wire logic                wb_ack_o,               // ack
  input wire logic                adc_valid,              // strobe
  input wire logic [10:0]         adc_sample,             // sample
  input wire logic                current_voltage_jumper, // 1 = v
  input wire logic [3:0]          dig_in,                 // inputs
  input wire logic signed [31:0]  process_value,          // scaled
  input wire logic                process_valid,          // in use
  input wire logic signed [31:0]  comparator_value,       // filtered
  input wire logic                input_active,           // enabled
  input wire logic                unit_is_volt            // unit
);
  import aic_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ****************************************************************
  // properties
  // ****************************************************************
  wire req_new = wb_req.cyc & wb_req.stb & ~wb_ack_o;
  property p_ack_rsp; req_new |=> wb_ack_o; endproperty
  a_ack_rsp: assert property (p_ack_rsp) else $error("ack missing");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
  property p_ack_cause; wb_ack_o |-> $past(req_new); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
  property p_pv_zero;
    (!process_valid)[*3] |-> process_value == 32'sh0;
  endproperty
  a_pv_zero: assert property (p_pv_zero) else $error("value leaks");
  property p_pv_eq;
    process_valid[*3] |-> process_value == comparator_value;
  endproperty
  a_pv_eq: assert property (p_pv_eq) else $error("paths differ");
  // unit only moves after a write; one extra cycle allowed for staging
  property p_unit_hold;
    $changed(unit_is_volt) |-> $past(wb_req.stb & wb_req.we)
      || $past(wb_req.stb & wb_req.we, 2);
  endproperty
  a_unit_hold: assert property (p_unit_hold) else $error("bad unit");
  property p_jmp;
    $changed(current_voltage_jumper) && !wb_req.stb |=> $stable(unit_is_volt);
  endproperty
  a_jmp: assert property (p_jmp) else $error("range followed jumper");
  property p_freeze;
    (!input_active)[*4] |-> $stable(comparator_value);
  endproperty
  a_freeze: assert property (p_freeze) else $error("filter ran");
  // limitation: fixed gap assumes TICK_CYC of 7 or more
  property p_step;
    $changed(comparator_value) |=> $stable(comparator_value)[*6];
  endproperty
  a_step: assert property (p_step) else $error("filter too fast");
  c_off: cover property (process_valid ##1 !process_valid);
  c_gate: cover property ((!input_active)[*4]);
  c_volt: cover property ($rose(unit_is_volt));
endmodule
bind aic_analog_input aic_analog_input_chk #(.TICK_CYC(TICK_CYC))
  aic_analog_input_chk_inst (.clk(clk), .rst(rst), .wb_req(wb_req),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .adc_valid(adc_valid),
  .adc_sample(adc_sample), .current_voltage_jumper(current_voltage_jumper),
  .dig_in(dig_in), .process_value(process_value),
  .process_valid(process_valid), .comparator_value(comparator_value),
  .input_active(input_active), .unit_is_volt(unit_is_volt));

/* File: sim/aic_analog_input_test.sv */
// self-checking bench for the analogue input conditioning block
// assumes TICK_CYC of 8 and the filter set to 1 ms for exact values
`timescale 1ns/1ps
module aic_analog_input_test;
  import aic_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  aic_wb_req_t wb_req = '0;
  logic [31:0] wb_dat_o, rd;
  logic        wb_ack_o, adc_valid, jmp = 1'b0, pvld, active, volt;
  logic [10:0] adc_sample, level = 11'h000;
  logic [3:0]  dig_in = 4'h0;
  logic signed [31:0] pval, cval;
  int miscompares = 0;
  int checks_done = 0;
  always #4 clk = ~clk;
  aic_adc_src aic_adc_src_inst (.clk(clk), .rst(rst), .level(level),
    .adc_valid(adc_valid), .adc_sample(adc_sample));
  aic_analog_input #(.TICK_CYC(8)) aic_analog_input_inst (.clk(clk),
    .rst(rst), .wb_req(wb_req), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .adc_valid(adc_valid), .adc_sample(adc_sample),
    .current_voltage_jumper(jmp), .dig_in(dig_in), .process_value(pval),
    .process_valid(pvld), .comparator_value(cval), .input_active(active),
    .unit_is_volt(volt));
  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask
  // one classic cycle; ack and data are taken at the same edge
  task automatic wb(input logic we, input logic [5:0] a,
                    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hf, dat: d};
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      chk("ack", 32'h1, 32'h0);
      finish_test();
    end
    rd = wb_dat_o;
    wb_req <= '0;
  endtask
  task automatic rchk(input string nm, input logic [5:0] a,
                      input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask
  function automatic logic [31:0] ctl(logic [1:0] f, logic [2:0] r,
                                      logic [1:0] e, lo, hi);
    return {14'h0, hi, 2'h0, lo, 2'h0, e, 1'h0, r, 2'h0, f};
  endfunction
  // six 1 ms steps is ample for a 1 ms time constant
  task automatic feed(input logic [10:0] v);
    @(posedge clk);
    level <= v;
    repeat (48) @(posedge clk);
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_defaults;
    rchk("ctrl", REG_CTRL, ctl(2'h3, 3'h0, 2'h0, 2'h0, 2'h1));
    rchk("span_lo", REG_SPAN_LOW, 32'h190);
    rchk("span_hi", REG_SPAN_HIGH, 32'h7d0);
    rchk("filter", REG_FILTER, 32'h64);
    rchk("unmapped", 6'h3c, 32'h0);
    $display("defaults done");
  endtask
  task automatic t_ranges;
    logic [2:0]  rc[5] = '{3'h0, 3'h0, 3'h1, 3'h4, 3'h5};
    logic [10:0] s[5] = '{11'h0c8, 11'h4b0, 11'h4b0, 11'h1f4, 11'h258};
    logic [31:0] e[5] = '{32'h0, 32'h1388, 32'h1770, 32'h1388, 32'h1388};
    wb(1'b1, REG_FILTER, 32'h0);
    rchk("filt_min", REG_FILTER, 32'h1);
    wb(1'b1, REG_PROC_MAX, 32'h2710);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      jmp <= rc[i][2];
      wb(1'b1, REG_CTRL, ctl(2'h3, rc[i], 2'h0, 2'h0, 2'h1));
      feed(s[i]);
      chk("proc", e[i], pval);
      chk("unit", {31'h0, rc[i][2]}, {31'h0, volt});
    end
    $display("ranges done");
  endtask
  task automatic t_jumper;
    @(posedge clk);
    jmp <= 1'b0;
    repeat (3) @(posedge clk);
    chk("unit", 32'h1, {31'h0, volt});
    wb(1'b1, REG_CTRL, ctl(2'h3, 3'h4, 2'h0, 2'h0, 2'h1));
    rchk("ctrl", REG_CTRL, ctl(2'h3, 3'h5, 2'h0, 2'h0, 2'h1));
    wb(1'b1, REG_CTRL, ctl(2'h3, 3'h1, 2'h0, 2'h0, 2'h1));
    rchk("ctrl", REG_CTRL, ctl(2'h3, 3'h1, 2'h0, 2'h0, 2'h1));
    $display("jumper done");
  endtask
  task automatic t_user;
    wb(1'b1, REG_SPAN_LOW, 32'hc8);
    rchk("span_lo", REG_SPAN_LOW, 32'h190);
    wb(1'b1, REG_CTRL, ctl(2'h3, 3'h2, 2'h0, 2'h2, 2'h2));
    wb(1'b1, REG_SPAN_LOW, 32'hc8);
    wb(1'b1, REG_SPAN_HIGH, 32'hbb8);
    rchk("span_hi", REG_SPAN_HIGH, 32'h7d0);
    wb(1'b1, REG_SPAN_HIGH, 32'h3e8);
    wb(1'b1, REG_LOW_USER, 32'hfffffc18);
    wb(1'b1, REG_HIGH_USER, 32'hbb8);
    feed(11'h258);
    chk("user", 32'h3e8, pval);
    wb(1'b1, REG_CTRL, ctl(2'h3, 3'h2, 2'h0, 2'h1, 2'h0));
    feed(11'h190);
    chk("swap", 32'h1d4c, pval);
    wb(1'b1, REG_LOW_USER, 32'h01312d00);
    rchk("lo_user", REG_LOW_USER, 32'h00989680);
    $display("user done");
  endtask
  task automatic t_func;
    wb(1'b1, REG_CTRL, ctl(2'h0, 3'h2, 2'h0, 2'h1, 2'h0));
    feed(11'h190);
    chk("valid", 32'h0, {31'h0, pvld});
    chk("proc", 32'h0, pval);
    chk("comp", 32'h1d4c, cval);
    wb(1'b1, REG_CTRL, ctl(2'h3, 3'h2, 2'h2, 2'h1, 2'h0));
    $display("function done");
  endtask
  task automatic t_gate;
    wb(1'b1, REG_DIN_FUNC, 32'h2c0b);
    feed(11'h0c8);
    chk("active", 32'h0, {31'h0, active});
    chk("frozen", 32'h1d4c, cval);
    dig_in <= 4'h4;
    feed(11'h0c8);
    chk("active", 32'h1, {31'h0, active});
    chk("comp", 32'h2710, cval);
    dig_in <= 4'h1;
    feed(11'h0c8);
    chk("active", 32'h1, {31'h0, active});
    wb(1'b1, REG_CTRL, ctl(2'h3, 3'h2, 2'h1, 2'h1, 2'h0));
    feed(11'h0c8);
    chk("active", 32'h0, {31'h0, active});
    dig_in <= 4'h0;
    feed(11'h0c8);
    chk("active", 32'h1, {31'h0, active});
    rchk("status", REG_STATUS, 32'h3);
    rchk("cond_val", REG_COND_VAL, 32'h2710);
    rchk("proc_val", REG_PROC_VAL, 32'h2710);
    $display("gate done");
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_defaults();
    t_ranges();
    t_jumper();
    t_user();
    t_func();
    t_gate();
    finish_test();
  end
endmodule
